//--- common/dct_pkg.sv
// constants shared by the dual counter/timer carrier unit
// assumes a plain register port with byte-wide data and 8-bit address
package dct_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] DCT_SHORT_CTRL_OFF  = 8'h00;
    localparam logic [7:0] DCT_SHARED_CTRL_OFF = 8'h01;
    localparam logic [7:0] DCT_LONG_CTRL_OFF   = 8'h02;
    localparam logic [7:0] DCT_SHORT_LOW_OFF   = 8'h04;
    localparam logic [7:0] DCT_SHORT_HIGH_OFF  = 8'h05;
    localparam logic [7:0] DCT_LONG_LOW_OFF    = 8'h06;
    localparam logic [7:0] DCT_LONG_HIGH_OFF   = 8'h07;
    localparam logic [7:0] DCT_CAPT_LOW_OFF    = 8'h08;
    localparam logic [7:0] DCT_CAPT_HIGH_OFF   = 8'h09;

    // ****************************************
    // control field positions
    // ****************************************
    localparam int DCT_RUN_BIT      = 7;
    localparam int DCT_SINGLE_BIT   = 6;
    localparam int DCT_FLAG_BIT     = 5;
    localparam int DCT_PRESC_HI     = 4;
    localparam int DCT_PRESC_LO     = 3;
    localparam int DCT_CAPMASK_BIT  = 2;
    localparam int DCT_TOMASK_BIT   = 1;
    localparam int DCT_ROUTE_BIT    = 0;
    // shared control
    localparam int DCT_MEASURE_BIT  = 7;
    localparam int DCT_SRCSEL_BIT   = 6;
    localparam int DCT_EDGE_HI      = 5;
    localparam int DCT_EDGE_LO      = 4;
    localparam int DCT_ALT_HI       = 3;
    localparam int DCT_ALT_LO       = 2;
    localparam int DCT_SHORT_INIT   = 1;
    localparam int DCT_LONG_INIT    = 0;

    // ****************************************
    // encodings and reset values
    // ****************************************
    localparam logic [1:0] DCT_ALT_MODE    = 2'h1;
    localparam logic [1:0] DCT_EDGE_FALL   = 2'h0;
    localparam logic [1:0] DCT_EDGE_RISE   = 2'h1;
    localparam logic [1:0] DCT_EDGE_BOTH   = 2'h2;
    localparam logic [1:0] DCT_PRESC_RST   = 2'h0;
    localparam logic [7:0] DCT_BYTE_RST    = 8'h00;
    localparam logic [15:0] DCT_WORD_RST   = 16'h0000;
    localparam logic [15:0] DCT_WORD_WRAP  = 16'hFFFF;
    localparam logic [7:0] DCT_SHORT_TERM  = 8'h01;
    localparam logic [15:0] DCT_LONG_TERM  = 16'h0001;

endpackage

//--- core/dct_timer.sv
// dual counter/timer carrier unit: 8-bit and 16-bit down counters
// assumes synchronous pin inputs and a plain one-cycle register port
//
// Functional notes
// - on enable the short output takes its initial level before counting
// - load takes low hold when output is 0, high hold when 1
// - one-shot short counter stops at zero, toggles, flags, interrupts
// - auto-reload first terminal count toggles only, reloads by level
// - auto-reload second terminal count toggles, flags and interrupts
// - hold registers writable anytime, used at next load
// - loaded zero wraps to FFh and is no timeout
// - two-bit field selects full, half, quarter, eighth clock rate
// - bit 2 masks capture interrupt, bit 1 masks timeout interrupt
// - flag, clock select and masks survive stop-mode recovery
// - bit 0 routes short output onto port3 pin4
// - measure one-shot ignores edges after the first, keeps counting
// - short timeout makes long counter capture without reload
// - writing one-shot 0 then 1 rearms one capture and reload
// - measure-mode long counter wraps from zero to FFFFh, flags and interrupts
// - short terminal count hands over to the long counter
// - long terminal count stops and re-enables the short counter
// - writing 00 to the mode field ends alternating operation
// - initial-level bit picks low when 0, high when 1
// - mode bit picks waveform when 0, measure when 1

`timescale 1ns/1ns

module dct_timer
    import dct_pkg::*;
(
    input  wire logic       CLOCK_I,
    input  wire logic       RST_N_I,
    input  wire logic       CE_I,
    input  wire logic       STOP_RECOVER_I,
    input  wire logic [7:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    input  wire logic       PORT3_PIN1_I,
    input  wire logic       PORT2_PIN0_I,
    input  wire logic       PORT3_DATA4_I,
    input  wire logic       PORT3_DATA5_I,
    output logic      [7:0] RDATA_O,
    output logic            PORT3_PIN4_O,
    output logic            PORT3_PIN5_O,
    output logic            SHORT_TIMEOUT_IRQ_O,
    output logic            LONG_TIMEOUT_IRQ_O,
    output logic            CAPTURE_IRQ_O
);

    // ****************************************
    // reset release
    // ****************************************
    logic       rst_meta_n;
    logic       rst_n;

    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // ****************************************
    // register state
    // ****************************************
    logic       s_run;
    logic       s_single;
    logic       s_flag;
    logic [1:0] presc_sel;
    logic       cap_mask;
    logic       s_to_mask;
    logic       s_route;
    logic [7:0] shared_ctl;
    logic       l_run;
    logic       l_single;
    logic       l_flag;
    logic       l_to_mask;
    logic       l_route;
    logic [7:0] short_low_hold;
    logic [7:0] short_high_hold;
    logic [7:0] long_low_hold;
    logic [7:0] long_high_hold;
    logic [15:0] capt;

    // ****************************************
    // counting state
    // ****************************************
    logic [2:0]  presc_cnt;
    logic        s_run_q;
    logic        l_run_q;
    logic [7:0]  s_cnt;
    logic [15:0] l_cnt;
    logic        short_output_level;
    logic        long_output_level;
    logic        s_half;
    logic        l_armed;
    logic        pin_q;

    // ****************************************
    // register decode
    // ****************************************
    wire wr_sc  = WR_I && (ADDR_I == DCT_SHORT_CTRL_OFF);
    wire wr_sh  = WR_I && (ADDR_I == DCT_SHARED_CTRL_OFF);
    wire wr_lc  = WR_I && (ADDR_I == DCT_LONG_CTRL_OFF);
    wire wr_sl  = WR_I && (ADDR_I == DCT_SHORT_LOW_OFF);
    wire wr_shh = WR_I && (ADDR_I == DCT_SHORT_HIGH_OFF);
    wire wr_ll  = WR_I && (ADDR_I == DCT_LONG_LOW_OFF);
    wire wr_lh  = WR_I && (ADDR_I == DCT_LONG_HIGH_OFF);

    wire [7:0] sc_rd = {s_run, s_single, s_flag, presc_sel,
                        cap_mask, s_to_mask, s_route};
    wire [7:0] lc_rd = {l_run, l_single, l_flag, 3'h0,
                        l_to_mask, l_route};

    wire [7:0] rd_mux =
        (ADDR_I == DCT_SHORT_CTRL_OFF)  ? sc_rd :
        (ADDR_I == DCT_SHARED_CTRL_OFF) ? shared_ctl :
        (ADDR_I == DCT_LONG_CTRL_OFF)   ? lc_rd :
        (ADDR_I == DCT_SHORT_LOW_OFF)   ? short_low_hold :
        (ADDR_I == DCT_SHORT_HIGH_OFF)  ? short_high_hold :
        (ADDR_I == DCT_LONG_LOW_OFF)    ? long_low_hold :
        (ADDR_I == DCT_LONG_HIGH_OFF)   ? long_high_hold :
        (ADDR_I == DCT_CAPT_LOW_OFF)    ? capt[7:0] :
        (ADDR_I == DCT_CAPT_HIGH_OFF)   ? capt[15:8] :
                                          DCT_BYTE_RST;

    // ****************************************
    // mode decode
    // ****************************************
    // mode select
    wire measure = shared_ctl[DCT_MEASURE_BIT];
    // alternating only valid in waveform mode
    wire alt = !measure &&
               (shared_ctl[DCT_ALT_HI:DCT_ALT_LO] == DCT_ALT_MODE);
    wire [1:0] edge_sel = shared_ctl[DCT_EDGE_HI:DCT_EDGE_LO];
    wire s_init = shared_ctl[DCT_SHORT_INIT];
    wire l_init = shared_ctl[DCT_LONG_INIT];

    // ****************************************
    // prescaler
    // ****************************************
    // tick every 1, 2, 4 or 8 clocks
    wire [2:0] presc_mask = 3'((4'h1 << presc_sel) - 4'h1);
    wire       tick = ((presc_cnt & presc_mask) == presc_mask);

    // ****************************************
    // short counter
    // ****************************************
    // start cycle after the run bit rises
    wire s_start = s_run && !s_run_q;
    wire s_tick  = s_run && s_run_q && tick;
    // only 1 -> 0 is terminal, 0 wraps to FFh
    wire s_term  = s_tick && (s_cnt == DCT_SHORT_TERM);
    // auto-reload: only the second half flags
    wire s_flag_set = s_term && (s_single || s_half);
    wire s_stop     = s_term && s_single;
    wire s_new_lvl  = !short_output_level;
    wire [7:0] s_load_init = s_init ? short_high_hold : short_low_hold;
    wire [7:0] s_load_next = s_new_lvl ? short_high_hold : short_low_hold;
    wire [7:0] next_s_cnt =
        s_start ? s_load_init :
        s_term  ? s_load_next :
        s_tick  ? 8'(s_cnt - 8'h01) : s_cnt;

    // ****************************************
    // long counter
    // ****************************************
    wire l_start = l_run && !l_run_q;
    wire l_tick  = l_run && l_run_q && tick;
    wire [15:0] l_hold = {long_high_hold, long_low_hold};
    wire l_wterm = !measure && l_tick && (l_cnt == DCT_LONG_TERM);
    wire l_wrap  = measure && l_tick && (l_cnt == DCT_WORD_RST);
    wire l_flag_set = l_wterm || l_wrap;
    wire l_stop  = l_wterm && l_single;

    // input edge detect on the selected source
    wire pin_now = shared_ctl[DCT_SRCSEL_BIT] ? PORT2_PIN0_I : PORT3_PIN1_I;
    wire rise    = pin_now && !pin_q;
    wire fall    = !pin_now && pin_q;
    wire edge_hit = (edge_sel == DCT_EDGE_RISE) ? rise :
                    (edge_sel == DCT_EDGE_FALL) ? fall :
                    (edge_sel == DCT_EDGE_BOTH) ? (rise || fall) : 1'b0;
    // one-shot accepts only the armed edge
    wire l_edge = measure && l_run && edge_hit && (!l_single || l_armed);
    wire l_tocap = measure && l_single && l_run && s_flag_set;
    wire capture = l_edge || l_tocap;
    // one-shot bit written 0 then 1 rearms
    wire l_rearm = wr_lc && WDATA_I[DCT_SINGLE_BIT] && !l_single;

    wire [15:0] next_l_cnt =
        (l_start && !measure) ? l_hold :
        l_edge  ? l_hold :
        l_wterm ? l_hold :
        l_wrap  ? DCT_WORD_WRAP :
        l_tick  ? 16'(l_cnt - 16'h0001) : l_cnt;

    // ****************************************
    // run bits with hand-over
    // ****************************************
    // short terminal in alternating hands over
    wire to_long  = alt && s_stop;
    // long terminal in alternating hands back
    wire to_short = alt && l_stop;

    wire next_s_run =
        to_short ? 1'b1 :
        s_stop   ? 1'b0 :
        wr_sc    ? WDATA_I[DCT_RUN_BIT] : s_run;
    wire next_l_run =
        to_long  ? 1'b1 :
        l_stop   ? 1'b0 :
        wr_lc    ? WDATA_I[DCT_RUN_BIT] : l_run;

    // flags: hardware set beats the clearing write
    wire next_s_flag = s_flag_set ||
        (s_flag && !(wr_sc && WDATA_I[DCT_FLAG_BIT]));
    wire next_l_flag = l_flag_set ||
        (l_flag && !(wr_lc && WDATA_I[DCT_FLAG_BIT]));

    wire next_pin4 = s_route ? short_output_level : PORT3_DATA4_I;
    wire next_pin5 = l_route ? long_output_level : PORT3_DATA5_I;

    // ****************************************
    // control registers
    // ****************************************
    // kept through stop recovery, power-on only
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            s_flag    <= 1'b0;
            presc_sel <= DCT_PRESC_RST;
            cap_mask  <= 1'b0;
            s_to_mask <= 1'b0;
            l_flag    <= 1'b0;
            l_to_mask <= 1'b0;
        end else if (CE_I) begin
            s_flag <= next_s_flag;
            l_flag <= next_l_flag;
            if (wr_sc) begin
                presc_sel <= WDATA_I[DCT_PRESC_HI:DCT_PRESC_LO];
                cap_mask  <= WDATA_I[DCT_CAPMASK_BIT];
                s_to_mask <= WDATA_I[DCT_TOMASK_BIT];
            end
            if (wr_lc) begin
                l_to_mask <= WDATA_I[DCT_TOMASK_BIT];
            end
        end
    end

    // stop recovery returns these to defaults
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            s_run    <= 1'b0;
            s_single <= 1'b0;
            s_route  <= 1'b0;
            l_run    <= 1'b0;
            l_single <= 1'b0;
            l_route  <= 1'b0;
        end else if (CE_I) begin
            if (STOP_RECOVER_I) begin
                s_run    <= 1'b0;
                s_single <= 1'b0;
                s_route  <= 1'b0;
                l_run    <= 1'b0;
                l_single <= 1'b0;
                l_route  <= 1'b0;
            end else begin
                s_run <= next_s_run;
                l_run <= next_l_run;
                if (wr_sc) begin
                    s_single <= WDATA_I[DCT_SINGLE_BIT];
                    s_route  <= WDATA_I[DCT_ROUTE_BIT];
                end
                if (wr_lc) begin
                    l_single <= WDATA_I[DCT_SINGLE_BIT];
                    l_route  <= WDATA_I[DCT_ROUTE_BIT];
                end
            end
        end
    end

    // hold registers accepted at any time
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            shared_ctl      <= DCT_BYTE_RST;
            short_low_hold  <= DCT_BYTE_RST;
            short_high_hold <= DCT_BYTE_RST;
            long_low_hold   <= DCT_BYTE_RST;
            long_high_hold  <= DCT_BYTE_RST;
        end else if (CE_I) begin
            if (wr_sh)
                shared_ctl <= WDATA_I;
            if (wr_sl)
                short_low_hold <= WDATA_I;
            if (wr_shh)
                short_high_hold <= WDATA_I;
            if (wr_ll)
                long_low_hold <= WDATA_I;
            if (wr_lh)
                long_high_hold <= WDATA_I;
        end
    end

    // ****************************************
    // short counter datapath
    // ****************************************
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            presc_cnt          <= 3'h0;
            s_run_q            <= 1'b0;
            s_cnt              <= DCT_BYTE_RST;
            short_output_level <= 1'b0;
            s_half             <= 1'b0;
        end else if (CE_I) begin
            // free-running so every rate shares one divider
            presc_cnt <= 3'(presc_cnt + 3'h1);
            s_run_q   <= s_run;
            s_cnt     <= next_s_cnt;
            if (s_start) begin
                short_output_level <= s_init;
                s_half             <= 1'b0;
            end else if (s_term) begin
                short_output_level <= s_new_lvl;
                s_half             <= !s_half;
            end
        end
    end

    // ****************************************
    // long counter datapath
    // ****************************************
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            l_run_q           <= 1'b0;
            l_cnt             <= DCT_WORD_RST;
            long_output_level <= 1'b0;
            l_armed           <= 1'b0;
            pin_q             <= 1'b0;
            capt              <= DCT_WORD_RST;
        end else if (CE_I) begin
            l_run_q <= l_run;
            l_cnt   <= next_l_cnt;
            pin_q   <= pin_now;
            if (l_start && !measure)
                long_output_level <= l_init;
            else if (l_wterm)
                long_output_level <= !long_output_level;
            // rearm, cleared by the edge it takes
            if (l_rearm || l_start)
                l_armed <= 1'b1;
            else if (l_edge)
                l_armed <= 1'b0;
            if (capture)
                capt <= l_cnt;
        end
    end

    // ****************************************
    // registered outputs
    // ****************************************
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            RDATA_O             <= DCT_BYTE_RST;
            PORT3_PIN4_O        <= 1'b0;
            PORT3_PIN5_O        <= 1'b0;
            SHORT_TIMEOUT_IRQ_O <= 1'b0;
            LONG_TIMEOUT_IRQ_O  <= 1'b0;
            CAPTURE_IRQ_O       <= 1'b0;
        end else if (CE_I) begin
            RDATA_O             <= RD_I ? rd_mux : DCT_BYTE_RST;
            PORT3_PIN4_O        <= next_pin4;
            PORT3_PIN5_O        <= next_pin5;
            SHORT_TIMEOUT_IRQ_O <= s_flag_set && s_to_mask;
            LONG_TIMEOUT_IRQ_O  <= l_flag_set && l_to_mask;
            CAPTURE_IRQ_O       <= capture && cap_mask;
        end
    end

endmodule

//--- test/dct_carrier_src.sv
// far-side model: carrier bursts on the measure input pins
// assumes the bench clock; pins change just after a rising edge
`timescale 1ns/1ns

module dct_carrier_src (
    input  wire logic CLOCK_I,
    input  wire logic burst_i,
    output logic      pin1_o,
    output logic      pin20_o
);
    logic [1:0] ph = 2'h0;
    logic       lvl = 1'b0;

    // line rests low between bursts, toggles every third clock inside
    always_ff @(posedge CLOCK_I) begin
        ph  <= (burst_i && ph != 2'h2) ? ph + 2'h1 : 2'h0;
        lvl <= (burst_i && ph == 2'h2) ? ~lvl : lvl & burst_i;
    end
    assign pin1_o  = lvl;
    // unselected source shows the inverse, never a stale copy
    assign pin20_o = ~lvl;
endmodule

//--- test/dct_timer_monitor.sv
// checker on the ports of the counter/timer top
// assumes one clock and the active-low power-on reset
`timescale 1ns/1ns

module dct_timer_monitor
    import dct_pkg::*;
(
    input wire logic       CLOCK_I,
    input wire logic       RST_N_I,
    input wire logic       STOP_RECOVER_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic       WR_I,
    input wire logic       RD_I,
    input wire logic       PORT3_DATA4_I,
    input wire logic [7:0] RDATA_O,
    input wire logic       PORT3_PIN4_O,
    input wire logic       SHORT_TIMEOUT_IRQ_O,
    input wire logic       LONG_TIMEOUT_IRQ_O,
    input wire logic       CAPTURE_IRQ_O
);
    // ****************************************
    // shadows of software writes
    // ****************************************
    logic [7:0] lo_sh;
    logic [7:0] hi_sh;
    logic       route_sh;
    logic       tom_sh;
    logic       capm_sh;
    logic       lmask_sh;
    wire        wr_sc = WR_I && ADDR_I == DCT_SHORT_CTRL_OFF;

    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            {lo_sh, hi_sh} <= 16'h0000;
            {route_sh, tom_sh, capm_sh, lmask_sh} <= 4'h0;
        end else begin
            if (wr_sc) begin
                tom_sh   <= WDATA_I[DCT_TOMASK_BIT];
                capm_sh  <= WDATA_I[DCT_CAPMASK_BIT];
            end
            if (STOP_RECOVER_I)
                route_sh <= 1'b0;
            else if (wr_sc)
                route_sh <= WDATA_I[DCT_ROUTE_BIT];
            if (WR_I && ADDR_I == DCT_LONG_CTRL_OFF)
                lmask_sh <= WDATA_I[DCT_TOMASK_BIT];
            if (WR_I && ADDR_I == DCT_SHORT_LOW_OFF)
                lo_sh <= WDATA_I;
            if (WR_I && ADDR_I == DCT_SHORT_HIGH_OFF)
                hi_sh <= WDATA_I;
        end
    end

    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);

    property p_rd_idle;
        !$past(RD_I) |-> RDATA_O == DCT_BYTE_RST;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data idle");
    property p_hold_rd;
        $past(RD_I) && ($past(ADDR_I) & 8'hFE) == DCT_SHORT_LOW_OFF
            |-> RDATA_O == ($past(ADDR_I[0]) ? hi_sh : lo_sh);
    endproperty
    a_hold_rd: assert property (p_hold_rd) else $error("hold readback");
    property p_s_pulse;
        SHORT_TIMEOUT_IRQ_O |=> !SHORT_TIMEOUT_IRQ_O;
    endproperty
    a_s_pulse: assert property (p_s_pulse) else $error("short irq");
    property p_l_pulse;
        LONG_TIMEOUT_IRQ_O |=> !LONG_TIMEOUT_IRQ_O;
    endproperty
    a_l_pulse: assert property (p_l_pulse) else $error("long irq");
    property p_s_mask;
        SHORT_TIMEOUT_IRQ_O |-> $past(tom_sh);
    endproperty
    a_s_mask: assert property (p_s_mask) else $error("short mask");
    property p_c_mask;
        CAPTURE_IRQ_O |-> $past(capm_sh);
    endproperty
    a_c_mask: assert property (p_c_mask) else $error("capture mask");
    property p_l_mask;
        LONG_TIMEOUT_IRQ_O |-> $past(lmask_sh);
    endproperty
    a_l_mask: assert property (p_l_mask) else $error("long mask");
    property p_pin_port;
        !$past(route_sh) |-> PORT3_PIN4_O == $past(PORT3_DATA4_I);
    endproperty
    a_pin_port: assert property (p_pin_port) else $error("pin4 port");
    property p_pin_tog;
        SHORT_TIMEOUT_IRQ_O && $past(route_sh)
            |=> PORT3_PIN4_O != $past(PORT3_PIN4_O);
    endproperty
    a_pin_tog: assert property (p_pin_tog) else $error("pin4 toggle");

    c_short: cover property (SHORT_TIMEOUT_IRQ_O && route_sh);
    c_long: cover property (LONG_TIMEOUT_IRQ_O);
    c_capt: cover property (CAPTURE_IRQ_O);
endmodule

bind dct_timer dct_timer_monitor u_dct_timer_monitor (
    .CLOCK_I            (CLOCK_I),
    .RST_N_I            (RST_N_I),
    .STOP_RECOVER_I     (STOP_RECOVER_I),
    .ADDR_I             (ADDR_I),
    .WDATA_I            (WDATA_I),
    .WR_I               (WR_I),
    .RD_I               (RD_I),
    .PORT3_DATA4_I      (PORT3_DATA4_I),
    .RDATA_O            (RDATA_O),
    .PORT3_PIN4_O       (PORT3_PIN4_O),
    .SHORT_TIMEOUT_IRQ_O(SHORT_TIMEOUT_IRQ_O),
    .LONG_TIMEOUT_IRQ_O (LONG_TIMEOUT_IRQ_O),
    .CAPTURE_IRQ_O      (CAPTURE_IRQ_O)
);

//--- test/dct_timer_bench.sv
// bench for the counter/timer top: registers, waveforms, measuring
// assumes the carrier source model and the bound checker
`timescale 1ns/1ns

module dct_timer_bench import dct_pkg::*;;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       stop = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wen = 1'b0;
    logic       ren = 1'b0;
    logic       d4 = 1'b0;
    logic       burst = 1'b0;
    logic       pin1;
    logic       pin20;
    logic [7:0] rdata;
    logic       pin4;
    logic       sirq;
    logic       lirq;
    logic       cirq;
    int         num_errors = 0;
    int         check_count = 0;
    int         cyc = 0;

    dct_timer u_dct_timer (
        .CLOCK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1), .STOP_RECOVER_I(stop),
        .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wen), .RD_I(ren),
        .PORT3_PIN1_I(pin1), .PORT2_PIN0_I(pin20), .PORT3_DATA4_I(d4),
        .PORT3_DATA5_I(1'b0), .RDATA_O(rdata), .PORT3_PIN4_O(pin4),
        .PORT3_PIN5_O(), .SHORT_TIMEOUT_IRQ_O(sirq),
        .LONG_TIMEOUT_IRQ_O(lirq), .CAPTURE_IRQ_O(cirq)
    );
    dct_carrier_src u_dct_carrier_src (
        .CLOCK_I(clk), .burst_i(burst), .pin1_o(pin1), .pin20_o(pin20)
    );

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic close_out;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic win(input int n, input int lo, input int hi);
        chk({7'h00, n >= lo && n <= hi}, 8'h01);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wen   <= 1'b1;
        @(posedge clk);
        wen <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        ren  <= 1'b1;
        @(posedge clk);
        ren <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic wrchk(input logic [7:0] a, input logic [7:0] d,
                         input logic [7:0] e);
        logic [7:0] v;
        wr(a, d);
        rd(a, v);
        chk(v, e);
    endtask
    // n counts rising edges after the launching write
    task automatic hold_for(input int sel, input int lim, inout int n);
        logic hit;
        hit = 1'b0;
        while (!hit && n < lim) begin
            @(posedge clk);
            #1;
            n++;
            hit = sel == 0 ? sirq === 1'b1 : sel == 1 ? lirq === 1'b1 :
                  sel == 2 ? cirq === 1'b1 : pin4 === 1'b1;
        end
    endtask
    task automatic run_short(input logic [7:0] ha, input logic [7:0] hv,
                             input logic [7:0] c, input int lim,
                             output int n);
        wr(ha, hv);
        wr(DCT_SHORT_CTRL_OFF, c);
        n = 1;
        hold_for(0, lim, n);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs;
        logic [7:0] v;
        rd(DCT_SHORT_CTRL_OFF, v);
        chk(v, DCT_BYTE_RST);
        wrchk(DCT_SHORT_LOW_OFF, 8'hA5, 8'hA5);
        wrchk(DCT_SHORT_HIGH_OFF, 8'h5A, 8'h5A);
        wrchk(8'h0F, 8'hFF, 8'h00);
        @(posedge clk);
        d4 <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk({7'h00, pin4}, 8'h01);
    endtask
    task automatic t_oneshot;
        int n;
        logic [7:0] v;
        wr(DCT_SHARED_CTRL_OFF, 8'h02);
        for (int k = 0; k < 4; k++) begin
            run_short(DCT_SHORT_HIGH_OFF, 8'h08, 8'hC3 | 8'(k << 3), 200, n);
            win(n, 7 * (1 << k) + 2, 8 * (1 << k) + 3);
            @(posedge clk);
            #1 chk({7'h00, pin4}, 8'h00);
            rd(DCT_SHORT_CTRL_OFF, v);
            chk(v, 8'h63 | 8'(k << 3));
            wr(DCT_SHORT_CTRL_OFF, 8'h20);
        end
    endtask
    task automatic t_auto;
        int n;
        wr(DCT_SHARED_CTRL_OFF, 8'h00);
        wr(DCT_SHORT_LOW_OFF, 8'h05);
        wr(DCT_SHORT_HIGH_OFF, 8'h03);
        wr(DCT_SHORT_CTRL_OFF, 8'h83);
        n = 1;
        hold_for(3, 40, n);
        win(n, 6, 8);
        chk({7'h00, sirq}, 8'h00);
        hold_for(0, 40, n);
        win(n, 9, 12);
        wr(DCT_SHORT_CTRL_OFF, 8'h20);
    endtask
    task automatic t_zero;
        int n;
        wr(DCT_SHARED_CTRL_OFF, 8'h02);
        run_short(DCT_SHORT_HIGH_OFF, 8'h00, 8'hC2, 300, n);
        win(n, 255, 261);
        wr(DCT_SHORT_CTRL_OFF, 8'h20);
    endtask
    task automatic t_alt;
        int n, m;
        wr(DCT_LONG_LOW_OFF, 8'h04);
        wr(DCT_LONG_HIGH_OFF, 8'h00);
        wr(DCT_LONG_CTRL_OFF, 8'h62);
        wr(DCT_SHARED_CTRL_OFF, 8'h04);
        run_short(DCT_SHORT_LOW_OFF, 8'h03, 8'hC2, 40, n);
        m = n;
        hold_for(1, 80, n);
        win(n - m, 3, 9);
        m = n;
        hold_for(0, 80, n);
        win(n - m, 3, 9);
        wr(DCT_SHARED_CTRL_OFF, 8'h00);
        n = 0;
        hold_for(0, 40, n);
        win(n, 40, 40);
        wr(DCT_LONG_CTRL_OFF, 8'h20);
        wr(DCT_SHORT_CTRL_OFF, 8'h20);
    endtask
    task automatic t_meas;
        int n;
        logic [7:0] lo;
        logic [7:0] hi;
        wr(DCT_SHORT_CTRL_OFF, 8'h24);
        wr(DCT_LONG_LOW_OFF, 8'h00);
        wr(DCT_LONG_HIGH_OFF, 8'h10);
        wr(DCT_SHARED_CTRL_OFF, 8'h90);
        wr(DCT_LONG_CTRL_OFF, 8'hC0);
        @(posedge clk);
        burst <= 1'b1;
        // let the edge capture settle before the short timeout
        repeat (12) @(posedge clk);
        wr(DCT_SHORT_LOW_OFF, 8'h10);
        wr(DCT_SHORT_CTRL_OFF, 8'hC4);
        n = 1;
        hold_for(2, 60, n);
        win(n, 17, 19);
        @(posedge clk);
        burst <= 1'b0;
        rd(DCT_CAPT_LOW_OFF, lo);
        rd(DCT_CAPT_HIGH_OFF, hi);
        win({16'h0000, hi, lo}, 32'h0FC0, 32'h0FF0);
        wr(DCT_LONG_CTRL_OFF, 8'h20);
        wr(DCT_SHARED_CTRL_OFF, 8'h00);
    endtask
    task automatic t_stop;
        logic [7:0] v;
        wrchk(DCT_SHORT_CTRL_OFF, 8'h3F, 8'h1F);
        @(posedge clk);
        stop <= 1'b1;
        @(posedge clk);
        stop <= 1'b0;
        rd(DCT_SHORT_CTRL_OFF, v);
        chk(v, 8'h1E);
    endtask

    initial forever #5 clk = ~clk;
    // hang guard, far above the few hundred cycles needed
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            close_out;
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs;
        t_oneshot;
        t_auto;
        t_zero;
        t_alt;
        t_meas;
        t_stop;
        close_out;
    end
endmodule
